// ==== verilog/stls_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module stls_top
    import stls_pkg::*;
#(
    parameter int LAMP_HOLD = LAMP_HOLD_CYC
) (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // AHB-Lite slave.
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Board pins.
    input  wire logic        diag_display_switch_in,
    input  wire logic        bus_init_in,
    // Activity pulses.
    input  wire logic        host_xfer_in,
    input  wire logic        drive_act_in,
    // Runtime fatal error report.
    input  wire logic        fatal_in,
    input  wire logic [7:0]  fatal_code_in,
    // Test engines.
    output logic             test_start_out,
    output logic      [2:0]  test_sel_out,
    input  wire logic        test_done_in,
    input  wire logic        test_fail_in,
    // Drive format engine.
    output logic             fmt_req_out,
    input  wire logic        fmt_done_in,
    // Lamps and interrupt.
    output logic             bus_activity_lamp_out,
    output logic             drive_activity_lamp_out,
    output logic             await_init_lamp_out,
    output logic             irq_out
);

    // Clean pin levels.
    logic diag_s;  // Diagnostic display switch.
    logic init_s;  // Host bus initialisation.
    // Stretched activity levels.
    logic bus_str;
    logic drv_str;

    // Bus slave state.
    logic        pend_q, pend_d;       // Data phase in progress.
    logic        pend_wr_q, pend_wr_d; // Pending access is a write.
    logic [3:0]  idx_q, idx_d;         // Pending register index.
    logic        rdy_q, rdy_d;         // Ready towards the master.
    logic [31:0] rdata_q, rdata_d;     // Read data.
    logic [31:0] rd_mux;               // Selected register value.
    logic        accept;               // Address phase taken.
    logic        wr_now;               // Write data stands now.
    logic        ip_wr, sa_wr, ctrl_wr, is_wr, im_wr;

    // Sequencer state.
    stls_state_t st_q, st_d;          // Test sequence state.
    logic [2:0]  tst_q, tst_d;        // Test being run.
    logic        issued_q, issued_d;  // Start sent for this test.
    logic        start_q, start_d;    // Start pulse to the engine.
    logic [7:0]  sa_code_q, sa_code_d; // Posted fatal code.
    logic        sa_fat_q, sa_fat_d;  // Fatal code valid.
    logic [2:0]  halt_q, halt_d;      // Held diagnostic pattern.
    logic        restart;             // Any restart cause.
    logic        p1_ev, p2_ev, fat_ev; // Sequencer events.

    // Format, lamp and interrupt state.
    logic                  fmt_q, fmt_d;     // Format request.
    logic                  fmt_ev;           // Format finished.
    logic [2:0]            lamp_q, lamp_d;   // {await, drive, bus}.
    logic [IRQ_W-1:0]      ist_q, ist_d;     // Sticky status.
    logic [IRQ_W-1:0]      imk_q, imk_d;     // Interrupt mask.
    logic [IRQ_W-1:0]      events;           // Event vector.
    logic                  irq_q, irq_d;     // Interrupt level.

    // Pins cross into the clock domain.
    stls_sync u_sync_diag (.clk_in(mclk_in), .rstn_in(rstn_in), .pin_in(diag_display_switch_in),
        .level_out(diag_s));
    stls_sync u_sync_init (.clk_in(mclk_in), .rstn_in(rstn_in), .pin_in(bus_init_in), .level_out(init_s));

    // Activity is stretched for the two flicker lamps.
    stls_stretch #(.HOLD(LAMP_HOLD)) u_str_bus (.clk_in(mclk_in), .rstn_in(rstn_in), .pulse_in(host_xfer_in),
        .lamp_out(bus_str));
    stls_stretch #(.HOLD(LAMP_HOLD)) u_str_drv (.clk_in(mclk_in), .rstn_in(rstn_in), .pulse_in(drive_act_in),
        .lamp_out(drv_str));

    // Write strobes fire in the single wait cycle of a write.
    assign accept  = hsel_in & htrans_in[1] & hready_in;
    assign wr_now  = pend_q & pend_wr_q;
    assign ip_wr   = wr_now & (idx_q == IDX_INIT_POLL);
    assign sa_wr   = wr_now & (idx_q == IDX_STATUS_ADDR);
    assign ctrl_wr = wr_now & (idx_q == IDX_CTRL);
    assign is_wr   = wr_now & (idx_q == IDX_IRQ_STAT);
    assign im_wr   = wr_now & (idx_q == IDX_IRQ_MASK);

    // Read multiplexer; unmapped indices read as zero.
    always_comb begin
        case (idx_q)
            IDX_STATUS_ADDR: rd_mux = {16'h0000, sa_fat_q, 7'h00, sa_code_q};
            IDX_CTRL:        rd_mux = {31'h00000000, fmt_q};
            IDX_IRQ_STAT:    rd_mux = {28'h0000000, ist_q};
            IDX_IRQ_MASK:    rd_mux = {28'h0000000, imk_q};
            IDX_STATE:       rd_mux = {21'h000000, tst_q, fmt_q, diag_s, lamp_q, st_q};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // Bus slave: every transfer takes one wait cycle.
    always_comb begin
        pend_d    = 1'b0;
        pend_wr_d = pend_wr_q;
        idx_d     = idx_q;
        rdy_d     = 1'b1;
        rdata_d   = rdata_q;
        if (pend_q) begin
            // Finish the data phase and present read data.
            rdata_d = pend_wr_q ? 32'h00000000 : rd_mux;
        end else if (accept) begin
            // Take the address phase and stall once.
            pend_d    = 1'b1;
            pend_wr_d = hwrite_in;
            idx_d     = (haddr_in[31:6] == 26'h0000000) ? haddr_in[5:2] : IDX_NONE;
            rdy_d     = 1'b0;
        end
    end

    // Register the bus slave.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_q    <= 1'b0;
            pend_wr_q <= 1'b0;
            idx_q     <= IDX_NONE;
            rdy_q     <= 1'b1;
            rdata_q   <= 32'h00000000;
        end else begin
            pend_q    <= pend_d;
            pend_wr_q <= pend_wr_d;
            idx_q     <= idx_d;
            rdy_q     <= rdy_d;
            rdata_q   <= rdata_d;
        end
    end

    // A halted diagnostic run ignores register restarts.
    assign restart = init_s | (ip_wr & (st_q != ST_HALT));

    // Self-test sequencer.
    always_comb begin
        st_d      = st_q;
        tst_d     = tst_q;
        issued_d  = issued_q;
        start_d   = 1'b0;
        sa_code_d = sa_code_q;
        sa_fat_d  = sa_fat_q;
        halt_d    = halt_q;
        p1_ev     = 1'b0;
        p2_ev     = 1'b0;
        fat_ev    = 1'b0;
        if (restart) begin
            // Hold in idle while bus init stands.
            st_d      = ST_IDLE;
            tst_d     = T_CPU;
            issued_d  = 1'b0;
            sa_code_d = RST_SA;
            sa_fat_d  = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // Begin phase one with the processor test.
                    st_d     = ST_P1;
                    tst_d    = T_CPU;
                    issued_d = 1'b0;
                end
                ST_P1, ST_P2: begin
                    if (!issued_q) begin
                        // Launch the current test once.
                        start_d  = 1'b1;
                        issued_d = 1'b1;
                    end else if (test_done_in) begin
                        issued_d = 1'b0;
                        if (test_fail_in) begin
                            // Post the fatal code for any failure.
                            sa_code_d = fatal_code_of(tst_q);
                            sa_fat_d  = 1'b1;
                            fat_ev    = 1'b1;
                            if (diag_s) begin
                                // Stop here and keep the error pattern.
                                st_d   = ST_HALT;
                                halt_d = lamp_code_of(tst_q);
                            end else begin
                                st_d = ST_FATAL;
                            end
                        end else if (tst_q == T_FMT) begin
                            // Phase one complete; wait for the host.
                            st_d  = ST_AWAIT;
                            p1_ev = 1'b1;
                        end else if (tst_q == T_PROM) begin
                            // Phase two complete.
                            st_d  = ST_PASS;
                            p2_ev = 1'b1;
                        end else begin
                            tst_d = tst_q + 3'h1;
                        end
                    end
                end
                ST_AWAIT: begin
                    // A host write to the status register starts init.
                    if (sa_wr) begin
                        st_d  = ST_P2;
                        tst_d = T_BUF;
                    end
                end
                ST_PASS, ST_FATAL, ST_HALT: st_d = st_q;
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
            // A fatal error while running also lands here.
            if (fatal_in && (st_q != ST_IDLE) && (st_q != ST_HALT) && (st_d != ST_HALT)) begin
                st_d      = ST_FATAL;
                sa_code_d = fatal_code_in;
                sa_fat_d  = 1'b1;
                fat_ev    = 1'b1;
            end
        end
    end

    // Register the sequencer.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q      <= ST_IDLE;
            tst_q     <= T_CPU;
            issued_q  <= 1'b0;
            start_q   <= 1'b0;
            sa_code_q <= RST_SA;
            sa_fat_q  <= 1'b0;
            halt_q    <= LAMP_OFF;
        end else begin
            st_q      <= st_d;
            tst_q     <= tst_d;
            issued_q  <= issued_d;
            start_q   <= start_d;
            sa_code_q <= sa_code_d;
            sa_fat_q  <= sa_fat_d;
            halt_q    <= halt_d;
        end
    end

    // Format request, only while no test runs.
    always_comb begin
        fmt_d  = fmt_q;
        fmt_ev = 1'b0;
        if (restart) begin
            fmt_d = 1'b0;
        end else if (fmt_q && fmt_done_in) begin
            // The engine formats only; no verify, no reassignment.
            fmt_d  = 1'b0;
            fmt_ev = 1'b1;
        end else if (ctrl_wr && hwdata_in[CTRL_FMT_BIT] && ((st_q == ST_AWAIT) || (st_q == ST_PASS))) begin
            fmt_d = 1'b1;
        end
    end

    // Lamp patterns follow the sequencer state.
    always_comb begin
        case (st_q)
            ST_AWAIT, ST_P2: lamp_d = LAMP_WAIT;
            ST_PASS:         lamp_d = {1'b0, drv_str, bus_str};
            ST_FATAL:        lamp_d = LAMP_FATAL;
            ST_HALT:         lamp_d = halt_q;
            default:         lamp_d = LAMP_OFF;
        endcase
    end

    // Sticky status: a new event wins over a write-one clear.
    assign events = {fmt_ev, fat_ev, p2_ev, p1_ev};
    always_comb begin
        ist_d = (ist_q & ~(is_wr ? hwdata_in[IRQ_W-1:0] : RST_IRQ)) | events;
        imk_d = im_wr ? hwdata_in[IRQ_W-1:0] : imk_q;
        irq_d = |(ist_q & imk_q);
    end

    // Register format, lamps and interrupt; lamps dark in reset.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fmt_q  <= 1'b0;
            lamp_q <= LAMP_OFF;
            ist_q  <= RST_IRQ;
            imk_q  <= RST_IRQ;
            irq_q  <= 1'b0;
        end else begin
            fmt_q  <= fmt_d;
            lamp_q <= lamp_d;
            ist_q  <= ist_d;
            imk_q  <= imk_d;
            irq_q  <= irq_d;
        end
    end

    // Outputs come straight from flip-flops, except hresp_out, which is tied to zero.
    assign hrdata_out              = rdata_q;
    assign hreadyout_out           = rdy_q;
    assign hresp_out               = 1'b0;
    assign test_start_out          = start_q;
    assign test_sel_out            = tst_q;
    assign fmt_req_out             = fmt_q;
    assign bus_activity_lamp_out   = lamp_q[0];
    assign drive_activity_lamp_out = lamp_q[1];
    assign await_init_lamp_out     = lamp_q[2];
    assign irq_out                 = irq_q;

endmodule
`default_nettype wire

// ==== verilog/stls_pkg.sv ====
`default_nettype none
// Shared constants for the self-test and lamp block.
package stls_pkg;
    // Clock and lamp stretch timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int LAMP_HOLD_US  = 10000;
    localparam int LAMP_HOLD_CYC = (LAMP_HOLD_US * 1000) / CLK_PERIOD_NS;
    // Register indices; byte address is four times the index.
    localparam logic [3:0] IDX_INIT_POLL   = 4'h0;
    localparam logic [3:0] IDX_STATUS_ADDR = 4'h2;
    localparam logic [3:0] IDX_CTRL        = 4'h3;
    localparam logic [3:0] IDX_IRQ_STAT    = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK    = 4'h5;
    localparam logic [3:0] IDX_STATE       = 4'h6;
    localparam logic [3:0] IDX_NONE        = 4'hf;
    // Field positions.
    localparam int SA_FATAL_BIT = 15;
    localparam int CTRL_FMT_BIT = 0;
    localparam int IRQ_P1_DONE  = 0;
    localparam int IRQ_P2_DONE  = 1;
    localparam int IRQ_FATAL    = 2;
    localparam int IRQ_FMT_DONE = 3;
    localparam int IRQ_W        = 4;
    // Reset values.
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
    localparam logic [7:0]       RST_SA  = 8'h00;
    // Test numbers in the order they run.
    localparam logic [2:0] T_CPU  = 3'h0;
    localparam logic [2:0] T_FMT  = 3'h1;
    localparam logic [2:0] T_BUF  = 3'h2;
    localparam logic [2:0] T_HAC  = 3'h3;
    localparam logic [2:0] T_RAM  = 3'h4;
    localparam logic [2:0] T_PROM = 3'h5;
    // Lamp patterns as {await, drive, bus}.
    localparam logic [2:0] LAMP_OFF   = 3'h0;
    localparam logic [2:0] LAMP_WAIT  = 3'h4;
    localparam logic [2:0] LAMP_FATAL = 3'h7;
    localparam logic [2:0] LC_CPU     = 3'h1;
    localparam logic [2:0] LC_FMT     = 3'h2;
    localparam logic [2:0] LC_BUF     = 3'h3;
    localparam logic [2:0] LC_HAC     = 3'h5;
    localparam logic [2:0] LC_PROM    = 3'h6;
    // Fatal codes posted in the status/address register.
    localparam logic [7:0] FC_RAM  = 8'h04;
    localparam logic [7:0] FC_PROM = 8'h05;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_P1    = 3'b001,
        ST_AWAIT = 3'b010,
        ST_P2    = 3'b011,
        ST_PASS  = 3'b100,
        ST_FATAL = 3'b101,
        ST_HALT  = 3'b110
    } stls_state_t;
    // Lamp error pattern for a failing test.
    function automatic logic [2:0] lamp_code_of(input logic [2:0] t);
        case (t)
            T_CPU:   lamp_code_of = LC_CPU;
            T_FMT:   lamp_code_of = LC_FMT;
            T_HAC:   lamp_code_of = LC_HAC;
            T_PROM:  lamp_code_of = LC_PROM;
            default: lamp_code_of = LC_BUF;
        endcase
    endfunction
    // Fatal code for a failing test; only the checksum test differs.
    function automatic logic [7:0] fatal_code_of(input logic [2:0] t);
        fatal_code_of = (t == T_PROM) ? FC_PROM : FC_RAM;
    endfunction
endpackage
`default_nettype wire

// ==== verilog/stls_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output moves once stages two and three agree.
module stls_sync (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // Pin and clean level.
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_q, s2_q, s3_q, o_q; // Stages and filtered level.
    logic o_d;                   // Next filtered level.

    // The filtered level follows only a settled value.
    always_comb begin
        o_d = (s2_q == s3_q) ? s3_q : o_q;
    end

    // Register the chain.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_q  <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            o_q  <= o_d;
        end
    end

    assign level_out = o_q;
endmodule
`default_nettype wire

// ==== verilog/stls_stretch.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stretches short activity pulses so that a lamp flicker is visible.
module stls_stretch #(
    parameter int HOLD = 4
) (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // Activity pulse and stretched level.
    input  wire logic pulse_in,
    output logic      lamp_out
);
    localparam int CW = $clog2(HOLD + 1);
    logic [CW-1:0] cnt_q, cnt_d; // Remaining hold cycles.
    logic          lit_q, lit_d; // Stretched level.

    // Reload on activity, otherwise count down to zero.
    always_comb begin
        if (pulse_in) begin
            cnt_d = CW'(HOLD);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end else begin
            cnt_d = cnt_q;
        end
        lit_d = (cnt_d != '0);
    end

    // Register the counter and level.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            lit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lit_q <= lit_d;
        end
    end

    assign lamp_out = lit_q;
endmodule
`default_nettype wire

// ==== verification/stls_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port checker.
module stls_top_monitor
    import stls_pkg::*;
(
    // Clock and reset.
    input wire logic        mclk_in,
    input wire logic        rstn_in,
    // Bus signals.
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    // Board, test, format.
    input wire logic        diag_display_switch_in,
    input wire logic        fatal_in,
    input wire logic        test_start_out,
    input wire logic [2:0]  test_sel_out,
    input wire logic        test_done_in,
    input wire logic        test_fail_in,
    input wire logic        fmt_req_out,
    input wire logic        fmt_done_in,
    // Lamps.
    input wire logic        bus_activity_lamp_out,
    input wire logic        drive_activity_lamp_out,
    input wire logic        await_init_lamp_out
);
    // Lamps as {await, drive, bus}.
    wire logic [2:0] lamps = {await_init_lamp_out, drive_activity_lamp_out, bus_activity_lamp_out};
    // Expected diagnostic pattern.
    wire logic [2:0] code_w = (test_sel_out == T_CPU) ? 3'h1 : (test_sel_out == T_FMT) ? 3'h2 :
                              (test_sel_out == T_HAC) ? 3'h5 : (test_sel_out == T_PROM) ? 3'h6 : 3'h3;
    // Engine results.
    wire logic pass_w = test_done_in && !test_fail_in;
    wire logic fail_w = test_done_in && test_fail_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    a_reset_dark: assert property (disable iff (1'h0) !rstn_in |-> lamps == 3'h0)
        else $error("lamps lit during reset");
    a_ready_blip: assert property (!hreadyout_out |=> hreadyout_out)
        else $error("long wait state");
    a_resp_okay: assert property (hresp_out == 1'h0)
        else $error("response not okay");
    a_start_pulse: assert property (test_start_out |=> !test_start_out)
        else $error("start not a pulse");
    a_ip_restart: assert property (hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in == 32'h0
        && !diag_display_switch_in |-> ##[1:12] test_start_out && test_sel_out == T_CPU)
        else $error("no restart");
    a_p1_await: assert property (pass_w && test_sel_out == T_FMT |-> ##[1:3] lamps == 3'h4)
        else $error("no await lamp");
    a_p2_dark: assert property (pass_w && test_sel_out == T_PROM |-> ##[1:3] lamps == 3'h0)
        else $error("lamps not off");
    a_fail_all: assert property (fail_w && !diag_display_switch_in |-> ##[1:3] lamps == 3'h7)
        else $error("fail not all lit");
    a_diag_code: assert property (fail_w && diag_display_switch_in |-> ##[1:3] lamps == code_w)
        else $error("bad lamp code");
    a_fatal_run: assert property (fatal_in && lamps == 3'h4 |-> ##[1:3] lamps == 3'h7)
        else $error("fatal not all lit");
    a_fmt_hold: assert property (fmt_req_out && !fmt_done_in |=> fmt_req_out)
        else $error("format dropped");
    a_fmt_drop: assert property (fmt_req_out && fmt_done_in |=> !fmt_req_out)
        else $error("format stuck");
    c_fail: cover property (fail_w);
    c_fmt: cover property (fmt_req_out && fmt_done_in);
    c_fatal: cover property (fatal_in && lamps == 3'h4);
endmodule
bind stls_top stls_top_monitor u_mon (.*);
`default_nettype wire

// ==== verification/stls_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Test and format engine model.
module stls_engine_model (
    // Clock and reset.
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Test engine; test fail_at_in fails.
    input  wire logic       start_in,
    input  wire logic [2:0] sel_in,
    input  wire logic [3:0] fail_at_in,
    output logic            done_out,
    output logic            fail_out,
    // Format engine.
    input  wire logic       fmt_req_in,
    output logic            fmt_done_out
);
    logic [2:0] sel;  // Test captured at start.
    int         n;    // Remaining delay.
    // Result line is noise unless done.
    initial begin
        done_out = 1'h0;
        fail_out = 1'h0;
        forever begin
            @(posedge clk_in);
            done_out <= 1'h0;
            fail_out <= 1'($urandom);
            if (rstn_in && start_in) begin
                sel = sel_in;
                for (n = 6 + $urandom % 7; n > 0 && rstn_in; n--) @(posedge clk_in);
                // A reset abandons the test in flight.
                if (rstn_in) begin
                    done_out <= 1'h1;
                    fail_out <= ({1'h0, sel} == fail_at_in);
                end
            end
        end
    end
    // Format done after a random stall.
    initial begin
        fmt_done_out = 1'h0;
        forever begin
            @(posedge clk_in);
            fmt_done_out <= 1'h0;
            if (fmt_req_in && !fmt_done_out) begin
                repeat (1 + $urandom % 10) @(posedge clk_in);
                fmt_done_out <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_self_test_led_status.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench.
module tb_self_test_led_status import stls_pkg::*;;
    localparam int HOLD = 8;  // Short lamp stretch.
    logic        mclk_in = 1'h0, rstn_in = 1'h0, hsel_in = 1'h0, hwrite_in = 1'h0, diag = 1'h0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
    logic [1:0]  htrans_in = 2'h0;
    logic        hreadyout_out, hresp_out, binit = 1'h0, xfer = 1'h0, drv = 1'h0, fatal = 1'h0;
    logic        start, done, fail, fmt_req, fmt_done, bus_l, drv_l, aw_l, irq;
    logic [7:0]  fcode = 8'h0;
    logic [2:0]  sel;
    logic [3:0]  fail_at = 4'h6;
    int          fails = 0, check_count = 0, cyc = 0;
    wire logic [2:0] lamps = {aw_l, drv_l, bus_l};
    stls_top #(.LAMP_HOLD(HOLD)) dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .diag_display_switch_in(diag),
        .bus_init_in(binit), .host_xfer_in(xfer), .drive_act_in(drv), .fatal_in(fatal),
        .fatal_code_in(fcode), .test_start_out(start), .test_sel_out(sel), .test_done_in(done),
        .test_fail_in(fail), .fmt_req_out(fmt_req), .fmt_done_in(fmt_done),
        .bus_activity_lamp_out(bus_l), .drive_activity_lamp_out(drv_l),
        .await_init_lamp_out(aw_l), .irq_out(irq));
    stls_engine_model u_eng (.clk_in(mclk_in), .rstn_in(rstn_in), .start_in(start), .sel_in(sel),
        .fail_at_in(fail_at), .done_out(done), .fail_out(fail), .fmt_req_in(fmt_req),
        .fmt_done_out(fmt_done));
    // Clock of 50 ns.
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    // Timeout.
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            conclude();
        end
    end
    // Compares and counts.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One word transfer; read data to rd.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge mclk_in);
        hsel_in <= 1'h1;
        haddr_in <= a;
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        do @(posedge mclk_in); while (hreadyout_out !== 1'h1);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge mclk_in); while (hreadyout_out !== 1'h1);
        rd = hrdata_out;
        hsel_in <= 1'h0;
    endtask
    // Bounded wait for a lamp pattern.
    task automatic wait_lamps(input logic [2:0] exp);
        for (int n = 0; n < 400 && lamps !== exp; n++) @(negedge mclk_in);
        chk(lamps, exp);
    endtask
    // Expected lamps when test k fails; six is all pass.
    function automatic logic [2:0] exp_lamp(input int k, input logic dg);
        return (k > 5) ? 3'h0 : !dg ? 3'h7 : (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : (k == 3) ? 3'h5 :
            (k == 5) ? 3'h6 : 3'h3;
    endfunction
    // Reset, run phase one and, for k of two or more, phase two; test k fails.
    task automatic run(input int k, input logic dg);
        @(posedge mclk_in);
        rstn_in <= 1'h0;
        diag <= dg;
        fail_at <= 4'(k);
        repeat (3) @(posedge mclk_in);
        chk(lamps, 3'h0);
        rstn_in <= 1'h1;
        if (k >= 2) begin
            wait_lamps(3'h4);
            bus(1'h1, 32'h8, $urandom);
        end
        wait_lamps(exp_lamp(k, dg));
        if (k < 6 && !dg) begin
            bus(1'h0, 32'h8, 32'h0);
            chk(rd, {16'h0, 1'h1, 7'h0, (k == 5) ? 8'h05 : 8'h04});
        end
        if (k < 6 && dg) begin
            bus(1'h1, 32'h0, 32'h0);
            repeat (30) @(negedge mclk_in);
            chk(lamps, exp_lamp(k, dg));
        end
        $display("run %0d %0d ended", k, dg);
    endtask
    // Main sequence.
    initial begin
        logic [7:0] c;
        void'($urandom(32'h12421e46));
        repeat (16) @(posedge mclk_in);
        rstn_in <= 1'h1;
        // Drive parameters stay with the host; no drive is used here.
        bus(1'h0, 32'h40, 32'h0);
        chk(rd, 32'h0);
        for (int dg = 0; dg < 2; dg++) begin
            for (int k = 0; k < 7; k++) begin
                run(k, dg[0]);
            end
        end
        run(6, 1'h0);
        @(posedge mclk_in) xfer <= 1'h1;
        @(posedge mclk_in) xfer <= 1'h0;
        repeat (3) @(negedge mclk_in);
        chk(lamps, 3'h1);
        @(posedge mclk_in) drv <= 1'h1;
        @(posedge mclk_in) drv <= 1'h0;
        repeat (3) @(negedge mclk_in);
        chk(lamps[1], 1'h1);
        repeat (HOLD + 6) @(negedge mclk_in);
        chk(lamps, 3'h0);
        $display("activity test ended");
        bus(1'h1, 32'h10, 32'hf);
        bus(1'h1, 32'hc, 32'h1);
        repeat (20) @(negedge mclk_in);
        chk(fmt_req, 1'h0);
        chk(irq, 1'h0);
        bus(1'h0, 32'h10, 32'h0);
        chk(rd, 32'h8);
        bus(1'h1, 32'h14, 32'h8);
        @(negedge mclk_in);
        chk(irq, 1'h1);
        bus(1'h1, 32'h10, 32'h8);
        @(negedge mclk_in);
        chk(irq, 1'h0);
        $display("format test ended");
        bus(1'h1, 32'h0, $urandom);
        wait_lamps(3'h4);
        c = 8'($urandom);
        @(posedge mclk_in);
        fatal <= 1'h1;
        fcode <= c;
        @(posedge mclk_in) fatal <= 1'h0;
        wait_lamps(3'h7);
        bus(1'h0, 32'h8, 32'h0);
        chk(rd, {16'h0, 1'h1, 7'h0, c});
        @(posedge mclk_in) binit <= 1'h1;
        repeat (10) @(posedge mclk_in);
        chk(lamps, 3'h0);
        binit <= 1'h0;
        wait_lamps(3'h4);
        $display("restart test ended");
        conclude();
    end
    // Prints counts and the verdict.
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
